// [hw/ccfu_pkg.sv]
// Package: flag register layout, operation codes and shared carriers
`default_nettype none
package ccfu_pkg;
   // ==========================================================
   // Flag register layout
   localparam int FLAG_W = 8;
   localparam int BIT_IMASK = 7;
   localparam int BIT_UIMASK = 6;
   localparam int BIT_HALF = 5;
   localparam int BIT_USER = 4;
   localparam int BIT_NEG = 3;
   localparam int BIT_ZERO = 2;
   localparam int BIT_OVF = 1;
   localparam int BIT_CARRY = 0;
   localparam logic [7:0] FLAGS_RESET = 8'h80;
   // ==========================================================
   // Half-carry tap positions per size
   localparam int HC_BYTE = 3;
   localparam int HC_WORD = 11;
   localparam int HC_LONG = 27;
   localparam int DATA_W = 32;
   localparam int ADDR_W = 24;

   typedef enum logic [1:0] {CCFU_SZ_BYTE, CCFU_SZ_WORD, CCFU_SZ_LONG} ccfu_size_t;

   typedef enum logic [3:0] {
      CCFU_OP_NONE, CCFU_OP_ADD, CCFU_OP_ADDX, CCFU_OP_SUB, CCFU_OP_SUBX,
      CCFU_OP_CMP, CCFU_OP_NEG, CCFU_OP_LOGIC, CCFU_OP_SHIFT,
      CCFU_OP_BITACC, CCFU_OP_LOAD, CCFU_OP_ANDI, CCFU_OP_ORI, CCFU_OP_XORI,
      CCFU_OP_DAA, CCFU_OP_DAS
   } ccfu_op_t;

   typedef enum logic [2:0] {
      CCFU_BIT_AND, CCFU_BIT_OR, CCFU_BIT_XOR, CCFU_BIT_LD
   } ccfu_bitop_t;

   // One execution-unit request
   typedef struct packed {
      logic valid;
      ccfu_op_t op;
      ccfu_size_t size;
      logic [DATA_W-1:0] a;
      logic [DATA_W-1:0] b;
      logic [7:0] imm;
      logic shift_out;
      logic [2:0] bit_sel;
      ccfu_bitop_t bit_op;
      logic bit_inv;
      logic [7:0] upd_mask;
   } ccfu_req_t;

   // Memory/fetch address request
   typedef struct packed {
      logic valid;
      logic fetch;
      ccfu_size_t size;
      logic [ADDR_W-1:0] addr;
   } ccfu_addr_t;
endpackage
`default_nettype wire

// [hw/ccfu_addr_align.sv]
// Even-address alignment for word, longword and fetch accesses
`default_nettype none
module ccfu_addr_align
   import ccfu_pkg::*;
(
   input wire logic ref_clk_i,            // CPU clock
   input wire logic reset_i,              // Sync reset
   input wire logic clk_en_i,             // Clock enable
   input wire ccfu_pkg::ccfu_addr_t req_i, // Address request
   output logic [ccfu_pkg::ADDR_W-1:0] addr_o, // Aligned address
   output logic valid_o                   // Address valid
);
   logic force_even;
   // No address error: odd word/long/fetch simply drops bit 0
   assign force_even = req_i.fetch || (req_i.size != CCFU_SZ_BYTE); // see RULE19 RULE20 RULE23
   always_ff @(posedge ref_clk_i) begin
      if (reset_i) begin
         addr_o <= '0;
         valid_o <= 1'b0;
      end else if (clk_en_i) begin
         valid_o <= req_i.valid;
         if (req_i.valid) begin
            addr_o <= {req_i.addr[ADDR_W-1:1], req_i.addr[0] & ~force_even};
         end
      end
   end
   a_even_align: assert property (@(posedge ref_clk_i) disable iff (reset_i) // see RULE19
      (clk_en_i && req_i.valid && req_i.size != CCFU_SZ_BYTE) |=> !addr_o[0])
      else $error("odd word access not aligned");
   a_fetch_align: assert property (@(posedge ref_clk_i) disable iff (reset_i) // see RULE20
      (clk_en_i && req_i.valid && req_i.fetch) |=> !addr_o[0])
      else $error("odd fetch not aligned");
endmodule
`default_nettype wire

// [hw/ccfu_flags.sv]
// Condition flag register, flag generation, interrupt gating and branch test
`default_nettype none
// Behaviour
// RULE1: Bit 7 set blocks all interrupts except non-maskable, always accepted.
// RULE2: Each exception sequence start sets bit 7.
// RULE3: Bit 6 is a software user bit, optionally an extra interrupt mask.
// RULE4: Byte add/sub/cmp/neg: half-carry from carry or borrow at bit 3.
// RULE5: Word add/sub/cmp/neg: half-carry from carry or borrow at bit 11.
// RULE6: Longword add/sub/cmp/neg: half-carry from carry or borrow at bit 27.
// RULE7: Bit 4 is a user bit read/written by control-register instructions.
// RULE8: Negative flag takes the result sign bit.
// RULE9: Zero flag set when result is zero, cleared otherwise.
// RULE10: Overflow flag set on arithmetic overflow, cleared otherwise.
// RULE11: Carry records add carry, sub borrow, shifted-out bit.
// RULE12: Bit instructions use carry as a one-bit accumulator.
// RULE13: Some ops preserve flags; register loadable and and/or/xor-immediate modifiable.
// RULE14: Conditional branch evaluates from negative, zero, overflow, carry.
// RULE15: Reset sets interrupt mask; other flags left undefined.
// RULE16: Software must initialise stack pointer with longword move after reset.
// RULE17: Handles 1,4,8,16,32-bit data; bit ops address bit 0..7 of byte.
// RULE18: Decimal adjust treats a byte as two packed BCD digits.
// RULE19: Odd word/longword accesses force address bit 0 to zero, no error.
// RULE20: Instruction fetches from odd addresses are aligned likewise.
// RULE21: Software should use word or longword sizes for stack accesses.
// RULE22: Pop is post-increment move; push is pre-decrement move.
// RULE23: Fetch treats program counter bit 0 as zero.
// RULE24: Per-instruction flag update set follows the supplied effect mask.
module ccfu_flags
   import ccfu_pkg::*;
(
   input wire logic ref_clk_i,               // CPU clock, 200 MHz
   input wire logic reset_i,                 // Sync reset, active high
   input wire logic clk_en_i,                // Freezes all state when low
   input wire ccfu_pkg::ccfu_req_t req_i,    // Execution request
   input wire logic exc_start_i,             // Exception sequence begins
   input wire logic irq_i,                   // Maskable interrupt pending
   input wire logic irq_ui_i,                // Interrupt gated also by bit 6
   input wire logic use_ui_mask_i,           // Bit 6 serves as a mask
   input wire logic nmi_i,                   // Non-maskable interrupt
   input wire logic [3:0] branch_cond_i,     // Branch condition code
   input wire ccfu_pkg::ccfu_addr_t addr_req_i, // Memory or fetch address
   input wire logic stack_op_i,              // Push or pop on stack pointer
   input wire logic stack_push_i,            // 1 push, 0 pop
   input wire logic [ccfu_pkg::DATA_W-1:0] sp_i, // Stack pointer value
   output logic [ccfu_pkg::FLAG_W-1:0] cpu_condition_flags_o, // Flag register
   output logic [ccfu_pkg::DATA_W-1:0] result_o, // Datapath result
   output logic irq_take_o,                  // Interrupt accepted
   output logic branch_taken_o,              // Branch condition true
   output logic [ccfu_pkg::ADDR_W-1:0] mem_addr_o, // Aligned address
   output logic mem_valid_o,                 // Aligned address valid
   output logic [ccfu_pkg::DATA_W-1:0] sp_next_o   // Stack pointer update
);
   // ==========================================================
   // Working signals
   logic [7:0] cpu_condition_flags_reg;
   logic [7:0] flags_next;
   logic [DATA_W-1:0] res;
   logic [DATA_W:0] sum;
   logic [12:0] nib_b;
   logic [28:0] nib_l;
   logic [4:0] nib_byte;
   logic carry_out, ovf, half;
   logic is_sub, cin, sign_a, sign_b, sign_r;
   logic [DATA_W-1:0] bb;
   logic [DATA_W-1:0] size_mask;
   logic bit_val, acc;
   logic [7:0] bcd_adj;
   logic bcd_c;

   always_comb begin
      case (req_i.size)
         CCFU_SZ_BYTE: size_mask = 32'h000000FF;
         CCFU_SZ_WORD: size_mask = 32'h0000FFFF;
         default: size_mask = 32'hFFFFFFFF;
      endcase
   end

   // ==========================================================
   // Adder: subtract as a + ~b + 1; NEG is 0 - a
   always_comb begin
      is_sub = (req_i.op == CCFU_OP_SUB) || (req_i.op == CCFU_OP_SUBX)
         || (req_i.op == CCFU_OP_CMP) || (req_i.op == CCFU_OP_NEG);
      cin = is_sub;
      if (req_i.op == CCFU_OP_ADDX) begin
         cin = cpu_condition_flags_reg[BIT_CARRY];
      end else if (req_i.op == CCFU_OP_SUBX) begin
         cin = ~cpu_condition_flags_reg[BIT_CARRY];
      end
      bb = is_sub ? ~req_i.b : req_i.b;
      if (req_i.op == CCFU_OP_NEG) begin
         bb = ~req_i.a;
      end
      sum = (req_i.op == CCFU_OP_NEG) ? ({1'b0, 32'h00000000} + {1'b0, bb} + {32'h0, cin})
         : ({1'b0, req_i.a} + {1'b0, bb} + {32'h0, cin});
      nib_byte = (req_i.op == CCFU_OP_NEG) ? ({1'b0, bb[3:0]} + {4'h0, cin})
         : ({1'b0, req_i.a[3:0]} + {1'b0, bb[3:0]} + {4'h0, cin});
      nib_b = (req_i.op == CCFU_OP_NEG) ? ({1'b0, bb[11:0]} + {12'h0, cin})
         : ({1'b0, req_i.a[11:0]} + {1'b0, bb[11:0]} + {12'h0, cin});
      nib_l = (req_i.op == CCFU_OP_NEG) ? ({1'b0, bb[27:0]} + {28'h0, cin})
         : ({1'b0, req_i.a[27:0]} + {1'b0, bb[27:0]} + {28'h0, cin});
   end

   // Carry, half carry and overflow taken at the operand size
   always_comb begin
      case (req_i.size)
         CCFU_SZ_BYTE: begin
            // Carry out of bit 7 is recovered from the full-width sum at bit 8
            carry_out = sum[8] ^ (req_i.op == CCFU_OP_NEG ? bb[8] : req_i.a[8] ^ bb[8]);
            half = nib_byte[HC_BYTE+1]; // see RULE4
            sign_r = sum[7];
            sign_a = (req_i.op == CCFU_OP_NEG) ? 1'b0 : req_i.a[7];
            sign_b = bb[7];
         end
         CCFU_SZ_WORD: begin
            carry_out = sum[16] ^ (req_i.op == CCFU_OP_NEG ? bb[16] : req_i.a[16] ^ bb[16]);
            half = nib_b[HC_WORD+1]; // see RULE5
            sign_r = sum[15];
            sign_a = (req_i.op == CCFU_OP_NEG) ? 1'b0 : req_i.a[15];
            sign_b = bb[15];
         end
         default: begin
            carry_out = sum[32];
            half = nib_l[HC_LONG+1]; // see RULE6
            sign_r = sum[31];
            sign_a = (req_i.op == CCFU_OP_NEG) ? 1'b0 : req_i.a[31];
            sign_b = bb[31];
         end
      endcase
      // Adder carry inverts to a borrow on subtraction
      if (is_sub) begin
         carry_out = ~carry_out; // see RULE11
         half = ~half;
      end
      ovf = (sign_a == sign_b) && (sign_r != sign_a); // see RULE10
   end

   // ==========================================================
   // Bit accumulator and decimal adjust
   always_comb begin
      bit_val = req_i.a[req_i.bit_sel] ^ req_i.bit_inv; // see RULE17
      acc = cpu_condition_flags_reg[BIT_CARRY];
      case (req_i.bit_op)
         CCFU_BIT_AND: acc = acc & bit_val; // see RULE12
         CCFU_BIT_OR: acc = acc | bit_val;
         CCFU_BIT_XOR: acc = acc ^ bit_val;
         default: acc = bit_val;
      endcase
   end

   always_comb begin
      bcd_adj = 8'h00;
      bcd_c = cpu_condition_flags_reg[BIT_CARRY];
      // Each BCD digit of the byte gets its own 6 adjust; for DAA the upper test also looks at the lower digit
      if (cpu_condition_flags_reg[BIT_HALF] || (req_i.a[3:0] > 4'h9)) begin // see RULE18
         bcd_adj[3:0] = 4'h6;
      end
      if (cpu_condition_flags_reg[BIT_CARRY] || (req_i.a[7:4] > 4'h9)
         || (req_i.op == CCFU_OP_DAA && req_i.a[7:4] == 4'h9 && req_i.a[3:0] > 4'h9)) begin
         bcd_adj[7:4] = 4'h6;
         bcd_c = (req_i.op == CCFU_OP_DAA) ? 1'b1 : bcd_c;
      end
   end

   // ==========================================================
   // Result selection
   always_comb begin
      case (req_i.op)
         CCFU_OP_LOGIC, CCFU_OP_SHIFT: res = req_i.a;
         CCFU_OP_DAA: res = {24'h0, req_i.a[7:0] + bcd_adj};
         CCFU_OP_DAS: res = {24'h0, req_i.a[7:0] - bcd_adj};
         default: res = sum[DATA_W-1:0];
      endcase
      res = res & size_mask;
   end

   // ==========================================================
   // Next flag value; upd_mask picks which bits the instruction touches
   always_comb begin
      flags_next = cpu_condition_flags_reg;
      case (req_i.op)
         CCFU_OP_ADD, CCFU_OP_ADDX, CCFU_OP_SUB, CCFU_OP_SUBX, CCFU_OP_CMP,
         CCFU_OP_NEG: begin
            flags_next[BIT_HALF] = half;
            flags_next[BIT_NEG] = sign_r; // see RULE8
            flags_next[BIT_ZERO] = (res == '0); // see RULE9
            flags_next[BIT_OVF] = ovf;
            flags_next[BIT_CARRY] = carry_out;
         end
         CCFU_OP_LOGIC, CCFU_OP_SHIFT: begin
            flags_next[BIT_NEG] = sign_r;
            flags_next[BIT_NEG] = (req_i.size == CCFU_SZ_BYTE) ? res[7]
               : (req_i.size == CCFU_SZ_WORD) ? res[15] : res[31];
            flags_next[BIT_ZERO] = (res == '0);
            flags_next[BIT_OVF] = 1'b0;
            flags_next[BIT_CARRY] = req_i.shift_out; // see RULE11
         end
         CCFU_OP_DAA, CCFU_OP_DAS: begin
            flags_next[BIT_NEG] = res[7];
            flags_next[BIT_ZERO] = (res == '0);
            flags_next[BIT_CARRY] = bcd_c;
         end
         CCFU_OP_BITACC: flags_next[BIT_CARRY] = acc;
         CCFU_OP_LOAD: flags_next = req_i.imm; // see RULE3 RULE7 RULE13
         CCFU_OP_ANDI: flags_next = cpu_condition_flags_reg & req_i.imm;
         CCFU_OP_ORI: flags_next = cpu_condition_flags_reg | req_i.imm;
         CCFU_OP_XORI: flags_next = cpu_condition_flags_reg ^ req_i.imm;
         default: flags_next = cpu_condition_flags_reg;
      endcase
      // Preserved bits keep their value
      flags_next = (flags_next & req_i.upd_mask)
         | (cpu_condition_flags_reg & ~req_i.upd_mask); // see RULE24 RULE13
   end

   // ==========================================================
   // Flag register
   always_ff @(posedge ref_clk_i) begin
      if (reset_i) begin
         // Only the mask has a defined value; the rest is zero here
         cpu_condition_flags_reg <= FLAGS_RESET; // see RULE15
      end else if (clk_en_i) begin
         if (exc_start_i) begin
            cpu_condition_flags_reg <= cpu_condition_flags_reg | FLAGS_RESET; // see RULE2
         end else if (req_i.valid) begin
            cpu_condition_flags_reg <= flags_next;
         end
      end
   end

   always_ff @(posedge ref_clk_i) begin
      if (reset_i) begin
         result_o <= '0;
      end else if (clk_en_i && req_i.valid) begin
         result_o <= res;
      end
   end

   // ==========================================================
   // Interrupt acceptance
   always_ff @(posedge ref_clk_i) begin
      if (reset_i) begin
         irq_take_o <= 1'b0;
      end else if (clk_en_i) begin
         irq_take_o <= nmi_i // see RULE1
            || (irq_i && !cpu_condition_flags_reg[BIT_IMASK]
               && !(irq_ui_i && use_ui_mask_i && cpu_condition_flags_reg[BIT_UIMASK])); // see RULE3
      end
   end

   // ==========================================================
   // Branch conditions from N, Z, V, C
   logic n_f, z_f, v_f, c_f, cond;
   always_comb begin
      n_f = cpu_condition_flags_reg[BIT_NEG];
      z_f = cpu_condition_flags_reg[BIT_ZERO];
      v_f = cpu_condition_flags_reg[BIT_OVF];
      c_f = cpu_condition_flags_reg[BIT_CARRY];
      case (branch_cond_i) // see RULE14
         4'h0: cond = 1'b1;
         4'h1: cond = 1'b0;
         4'h2: cond = !(c_f || z_f);
         4'h3: cond = c_f || z_f;
         4'h4: cond = !c_f;
         4'h5: cond = c_f;
         4'h6: cond = !z_f;
         4'h7: cond = z_f;
         4'h8: cond = !v_f;
         4'h9: cond = v_f;
         4'hA: cond = !n_f;
         4'hB: cond = n_f;
         4'hC: cond = (n_f == v_f);
         4'hD: cond = (n_f != v_f);
         4'hE: cond = !z_f && (n_f == v_f);
         default: cond = z_f || (n_f != v_f);
      endcase
   end

   always_ff @(posedge ref_clk_i) begin
      if (reset_i) begin
         branch_taken_o <= 1'b0;
      end else if (clk_en_i) begin
         branch_taken_o <= cond;
      end
   end

   // ==========================================================
   // Stack pointer step: push pre-decrements, pop post-increments
   logic [DATA_W-1:0] step;
   assign step = (addr_req_i.size == CCFU_SZ_LONG) ? 32'h00000004 : 32'h00000002;
   always_ff @(posedge ref_clk_i) begin
      if (reset_i) begin
         sp_next_o <= '0;
      end else if (clk_en_i && stack_op_i) begin
         sp_next_o <= stack_push_i ? (sp_i - step) : (sp_i + step); // see RULE22
      end
   end

   ccfu_addr_align u_align (
      .ref_clk_i(ref_clk_i),
      .reset_i(reset_i),
      .clk_en_i(clk_en_i),
      .req_i(addr_req_i),
      .addr_o(mem_addr_o),
      .valid_o(mem_valid_o)
   );

   assign cpu_condition_flags_o = cpu_condition_flags_reg;

   // ==========================================================
   // Checks
   a_nmi_always: assert property (@(posedge ref_clk_i) disable iff (reset_i) // see RULE1
      (clk_en_i && nmi_i) |=> irq_take_o)
      else $error("nmi not accepted");
   a_mask_blocks: assert property (@(posedge ref_clk_i) disable iff (reset_i) // see RULE1
      (clk_en_i && !nmi_i && cpu_condition_flags_reg[BIT_IMASK]) |=> !irq_take_o)
      else $error("masked interrupt accepted");
   a_exc_sets_mask: assert property (@(posedge ref_clk_i) disable iff (reset_i) // see RULE2
      (clk_en_i && exc_start_i) |=> cpu_condition_flags_reg[BIT_IMASK])
      else $error("exception did not set mask");
   a_zero_flag: assert property (@(posedge ref_clk_i) disable iff (reset_i) // see RULE9
      (clk_en_i && req_i.valid && !exc_start_i && req_i.op == CCFU_OP_ADD
         && req_i.upd_mask[BIT_ZERO]) |=> (cpu_condition_flags_reg[BIT_ZERO] == (result_o == '0)))
      else $error("zero flag mismatch");
   a_byte_half: assert property (@(posedge ref_clk_i) disable iff (reset_i) // see RULE4
      (clk_en_i && req_i.valid && !exc_start_i && req_i.op == CCFU_OP_ADD
         && req_i.size == CCFU_SZ_BYTE && req_i.upd_mask[BIT_HALF])
      |=> cpu_condition_flags_reg[BIT_HALF]
         == ((({1'b0, $past(req_i.a[3:0])} + {1'b0, $past(req_i.b[3:0])}) >> 4) != 5'h00))
      else $error("byte half carry wrong");
   a_preserve_bits: assert property (@(posedge ref_clk_i) disable iff (reset_i) // see RULE24
      (clk_en_i && req_i.valid && !exc_start_i && req_i.upd_mask == 8'h00)
      |=> $stable(cpu_condition_flags_reg))
      else $error("preserved flags changed");
   a_load_flags: assert property (@(posedge ref_clk_i) disable iff (reset_i) // see RULE13
      (clk_en_i && req_i.valid && !exc_start_i && req_i.op == CCFU_OP_LOAD
         && req_i.upd_mask == 8'hFF) |=> cpu_condition_flags_reg == $past(req_i.imm))
      else $error("flag load failed");
   a_stack_push: assert property (@(posedge ref_clk_i) disable iff (reset_i) // see RULE22
      (clk_en_i && stack_op_i && stack_push_i && addr_req_i.size == CCFU_SZ_LONG)
      |=> sp_next_o == $past(sp_i) - 32'h00000004)
      else $error("push step wrong");
endmodule
`default_nettype wire

// [tb/ccfu_irq_model.sv]
// Interrupt and exception source model standing in for the sequencer side
`default_nettype none
module ccfu_irq_model (
   input wire logic ref_clk_i, // CPU clock
   output logic irq_o,         // Maskable request
   output logic irq_ui_o,      // Request also gated by bit 6
   output logic use_ui_mask_o, // Bit 6 acts as an extra mask
   output logic nmi_o,         // Non-maskable request
   output logic exc_start_o    // Exception sequence start
);
   timeunit 1ns;
   timeprecision 1ps;
   initial begin
      {irq_o, irq_ui_o, use_ui_mask_o, nmi_o, exc_start_o} = '0;
   end
   // Called in the falling-edge time step; levels hold until the next call
   task automatic post(input logic [3:0] lv);
      {irq_o, irq_ui_o, use_ui_mask_o, nmi_o} <= lv;
   endtask
   // The sequencer never stretches the start pulse beyond one cycle
   task automatic exc_pulse();
      exc_start_o <= 1'b1;
      @(negedge ref_clk_i);
      exc_start_o <= 1'b0;
   endtask
endmodule
`default_nettype wire

// [tb/ccfu_flags_tb.sv]
// Self-checking bench for the condition flag unit
`default_nettype none
module ccfu_flags_tb;
   timeunit 1ns;
   timeprecision 1ps;
   import ccfu_pkg::*;
   // ==========================================================
   // Stimulus and observed signals
   logic clk = 1'b0;
   logic rst = 1'b1;
   logic clk_en = 1'b1;
   ccfu_req_t req = '0;
   ccfu_addr_t areq = '0;
   logic [3:0] cond = 4'h0;
   logic stk_op = 1'b0;
   logic stk_push = 1'b0;
   logic [31:0] sp = 32'h0;
   logic irq, irq_ui, use_ui, nmi, exc, irq_take, br_taken, mem_valid;
   logic [7:0] flags;
   logic [31:0] result, sp_next;
   logic [23:0] mem_addr;
   logic [7:0] exp_fl = 8'h80;
   int failures = 0;
   int n_compared = 0;
   initial begin
      forever #2.5 clk = ~clk;
   end
   ccfu_irq_model irq_u (.ref_clk_i(clk), .irq_o(irq), .irq_ui_o(irq_ui),
      .use_ui_mask_o(use_ui), .nmi_o(nmi), .exc_start_o(exc));
   ccfu_flags dut_u (.ref_clk_i(clk), .reset_i(rst), .clk_en_i(clk_en), .req_i(req),
      .exc_start_i(exc), .irq_i(irq), .irq_ui_i(irq_ui), .use_ui_mask_i(use_ui),
      .nmi_i(nmi), .branch_cond_i(cond), .addr_req_i(areq), .stack_op_i(stk_op),
      .stack_push_i(stk_push), .sp_i(sp), .cpu_condition_flags_o(flags),
      .result_o(result), .irq_take_o(irq_take), .branch_taken_o(br_taken),
      .mem_addr_o(mem_addr), .mem_valid_o(mem_valid), .sp_next_o(sp_next));
   // ==========================================================
   // Checking helpers
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      n_compared++;
      if (seen !== exp) begin
         failures++;
         $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask
   task automatic stop_test();
      if (failures == 0 && n_compared > 0) begin
         $display("No errors found");
      end else begin
         $display("Errors were found");
      end
      $finish;
   endtask
   // Requests stay valid back to back; the caller drops valid when done
   task automatic gen(input ccfu_req_t r, input logic [7:0] nf);
      r.valid = 1'b1;
      req <= r;
      @(negedge clk);
      exp_fl = (exp_fl & ~r.upd_mask) | (nf & r.upd_mask);
      check(flags, exp_fl);
   endtask
   task automatic fop(input ccfu_op_t op, input logic [7:0] v);
      ccfu_req_t r;
      r = '0;
      r.op = op;
      r.imm = v;
      r.upd_mask = 8'hFF;
      case (op)
         CCFU_OP_ANDI: gen(r, exp_fl & v);
         CCFU_OP_ORI: gen(r, exp_fl | v);
         CCFU_OP_XORI: gen(r, exp_fl ^ v);
         default: gen(r, v);
      endcase
   endtask
   // Wide arithmetic makes the carry and half-carry taps plain bit picks
   task automatic arith(input ccfu_op_t op, input ccfu_size_t sz,
                        input logic [31:0] a, input logic [31:0] b);
      ccfu_req_t r;
      logic [63:0] wm, hm, ra, rb, s, h;
      logic sub, ci;
      logic [7:0] nf;
      int w, hb;
      w = sz == CCFU_SZ_BYTE ? 8 : sz == CCFU_SZ_WORD ? 16 : 32;
      hb = sz == CCFU_SZ_BYTE ? HC_BYTE : sz == CCFU_SZ_WORD ? HC_WORD : HC_LONG;
      sub = op inside {CCFU_OP_SUB, CCFU_OP_SUBX, CCFU_OP_CMP, CCFU_OP_NEG};
      ci = (op inside {CCFU_OP_ADDX, CCFU_OP_SUBX}) ? exp_fl[BIT_CARRY] : 1'b0;
      ra = op == CCFU_OP_NEG ? 64'h0 : 64'(a);
      rb = op == CCFU_OP_NEG ? 64'(a) : 64'(b);
      wm = (64'h1 << w) - 64'h1;
      hm = (64'h1 << (hb + 1)) - 64'h1;
      s = sub ? (ra & wm) - (rb & wm) - 64'(ci) : (ra & wm) + (rb & wm) + 64'(ci);
      h = sub ? (ra & hm) - (rb & hm) - 64'(ci) : (ra & hm) + (rb & hm) + 64'(ci);
      nf = '0;
      nf[BIT_HALF] = h[hb+1];
      nf[BIT_NEG] = s[w-1];
      nf[BIT_ZERO] = (s & wm) == 64'h0;
      nf[BIT_OVF] = (ra[w-1] ^ rb[w-1] ^ !sub) & (s[w-1] ^ ra[w-1]);
      nf[BIT_CARRY] = s[w];
      r = '0;
      r.op = op;
      r.size = sz;
      r.a = a;
      r.b = b;
      r.upd_mask = (op inside {CCFU_OP_ADDX, CCFU_OP_SUBX}) ? 8'h2B : 8'h2F;
      gen(r, nf);
      if (op != CCFU_OP_CMP) check(result, 32'(s & wm));
   endtask
   function automatic logic br_exp(input logic [3:0] c, input logic [7:0] f);
      logic n, z, v, cy, t;
      {n, z, v, cy} = f[3:0];
      case (c[3:1])
         3'h0: t = 1'b1;
         3'h1: t = !(cy | z);
         3'h2: t = !cy;
         3'h3: t = !z;
         3'h4: t = !v;
         3'h5: t = !n;
         3'h6: t = !(n ^ v);
         default: t = !(z | (n ^ v));
      endcase
      return t ^ c[0];
   endfunction
   // ==========================================================
   // Test sequence
   initial begin
      ccfu_req_t r;
      ccfu_addr_t a;
      logic [7:0] nf;
      logic b, c;
      logic [12:0] it [6];
      int e;
      it = '{{8'h00, 4'h8, 1'b1}, {8'h80, 4'h8, 1'b0}, {8'h80, 4'h1, 1'b1},
             {8'h40, 4'hE, 1'b0}, {8'h00, 4'hE, 1'b1}, {8'h40, 4'hC, 1'b1}};
      repeat (6) @(negedge clk);
      rst <= 1'b0;
      @(negedge clk);
      check(flags, 8'h80);
      check(result, 32'h0);
      arith(CCFU_OP_ADD, CCFU_SZ_BYTE, 32'h0F, 32'h01);
      arith(CCFU_OP_ADD, CCFU_SZ_BYTE, 32'h7F, 32'h01);
      arith(CCFU_OP_ADD, CCFU_SZ_BYTE, 32'hFF, 32'h01);
      arith(CCFU_OP_ADDX, CCFU_SZ_BYTE, 32'h10, 32'h01);
      arith(CCFU_OP_SUB, CCFU_SZ_BYTE, 32'h10, 32'h01);
      arith(CCFU_OP_SUB, CCFU_SZ_BYTE, 32'h00, 32'h01);
      arith(CCFU_OP_SUBX, CCFU_SZ_BYTE, 32'h05, 32'h01);
      arith(CCFU_OP_CMP, CCFU_SZ_BYTE, 32'h80, 32'h01);
      arith(CCFU_OP_NEG, CCFU_SZ_BYTE, 32'h01, 32'h00);
      arith(CCFU_OP_ADD, CCFU_SZ_WORD, 32'h0FFF, 32'h0001);
      arith(CCFU_OP_SUB, CCFU_SZ_WORD, 32'h1000, 32'h0001);
      arith(CCFU_OP_CMP, CCFU_SZ_WORD, 32'h8000, 32'h0001);
      arith(CCFU_OP_ADD, CCFU_SZ_LONG, 32'h0FFFFFFF, 32'h1);
      arith(CCFU_OP_NEG, CCFU_SZ_LONG, 32'h1, 32'h0);
      arith(CCFU_OP_ADD, CCFU_SZ_LONG, 32'hFFFFFFFF, 32'h1);
      fop(CCFU_OP_LOAD, 8'h5A);
      fop(CCFU_OP_ANDI, 8'hEF);
      fop(CCFU_OP_ORI, 8'h10);
      fop(CCFU_OP_XORI, 8'h50);
      r = '0;
      r.op = CCFU_OP_DAA;
      r.a = 32'h0A;
      r.upd_mask = 8'h0D;
      gen(r, 8'h00);
      check(result, 32'h10);
      r.op = CCFU_OP_LOGIC;
      r.size = CCFU_SZ_WORD;
      r.a = 32'h18000;
      r.upd_mask = 8'h0E;
      gen(r, 8'h08);
      check(result, 32'h8000);
      r = '0;
      r.op = CCFU_OP_SHIFT;
      r.a = 32'h80;
      r.shift_out = 1'b1;
      r.upd_mask = 8'h0F;
      gen(r, 8'h09);
      for (int k = 0; k < 8; k++) begin
         r = '0;
         r.op = CCFU_OP_BITACC;
         r.a = 32'hA5;
         r.bit_sel = 3'(k);
         r.bit_op = ccfu_bitop_t'(k % 4);
         r.bit_inv = k[2];
         r.upd_mask = 8'h01;
         b = r.a[k] ^ r.bit_inv;
         c = exp_fl[BIT_CARRY];
         nf = {7'h0, k % 4 == 0 ? c & b : k % 4 == 1 ? c | b : k % 4 == 2 ? c ^ b : b};
         gen(r, nf);
      end
      for (int k = 0; k < 16; k += 3) begin
         fop(CCFU_OP_LOAD, 8'(k));
         req.valid <= 1'b0;
         for (int c4 = 0; c4 < 16; c4++) begin
            cond <= 4'(c4);
            @(negedge clk);
            check(br_taken, br_exp(4'(c4), exp_fl));
         end
      end
      for (int k = 0; k < 6; k++) begin
         fop(CCFU_OP_LOAD, it[k][12:5]);
         req.valid <= 1'b0;
         irq_u.post(it[k][4:1]);
         @(negedge clk);
         check(irq_take, it[k][0]);
      end
      irq_u.post(4'h0);
      fop(CCFU_OP_LOAD, 8'h00);
      r = '0;
      r.valid = 1'b1;
      r.op = CCFU_OP_LOAD;
      r.imm = 8'h55;
      r.upd_mask = 8'hFF;
      req <= r;
      irq_u.exc_pulse();
      exp_fl = 8'h80;
      check(flags, exp_fl);
      clk_en <= 1'b0;
      r.imm = 8'h3C;
      req <= r;
      @(negedge clk);
      check(flags, exp_fl);
      clk_en <= 1'b1;
      req.valid <= 1'b0;
      for (int k = 0; k < 4; k++) begin
         a.valid = 1'b1;
         a.fetch = k == 0;
         a.size = k == 1 ? CCFU_SZ_WORD : k == 2 ? CCFU_SZ_LONG : CCFU_SZ_BYTE;
         a.addr = 24'h123457;
         areq <= a;
         @(negedge clk);
         check(mem_addr, k == 3 ? 24'h123457 : 24'h123456);
         check(mem_valid, 1'b1);
      end
      for (int k = 0; k < 4; k++) begin
         a.valid = 1'b0;
         a.size = k[1] ? CCFU_SZ_LONG : CCFU_SZ_WORD; // Word or longword only
         areq <= a;
         r.size = a.size;
         r.valid = 1'b0;
         req <= r;
         stk_op <= 1'b1;
         stk_push <= k[0];
         sp <= 32'h1000; // Defined before any stack use
         e = k[1] ? 4 : 2;
         @(negedge clk);
         check(sp_next, k[0] ? 32'h1000 - 32'(e) : 32'h1000 + 32'(e));
      end
      stk_op <= 1'b0;
      stop_test();
   end
   // Hang guard: the full sequence needs well under this many cycles
   initial begin
      repeat (20000) @(posedge clk);
      failures++;
      stop_test();
   end
endmodule
`default_nettype wire
